// ### core/watchdog_reload_unlock_pkg.sv
// Constants shared by the reloadable watchdog and its register port.
package watchdog_reload_unlock_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int COUNT_W = 24;
  // Register addresses on the byte port.
  localparam logic [11:0] ADDR_UNLOCK_PORT = 12'hff0;
  localparam logic [11:0] ADDR_RELOAD_UPPER = 12'hff1;
  localparam logic [11:0] ADDR_RELOAD_MIDDLE = 12'hff2;
  localparam logic [11:0] ADDR_RELOAD_LOWER = 12'hff3;
  // Unlock codes written to the unlock port.
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'haa;
  // Reload value after reset and the wrap value after an interrupt time-out.
  localparam logic [23:0] RELOAD_RESET = 24'hffffff;
  localparam logic [23:0] COUNT_MAX = 24'hffffff;
  // Refresh is refused once the count is at or below this value.
  localparam logic [23:0] REFRESH_FLOOR = 24'h000002;
  localparam logic [23:0] COUNT_ZERO = 24'h000000;
  localparam logic [23:0] COUNT_ONE = 24'h000001;
  // Reset status byte read at the unlock port address.
  localparam int STATUS_TIMEOUT_BIT = 5;
  localparam int STATUS_STOP_BIT = 4;
  // Nominal oscillator rate; the counter advances once per oscillator rising edge.
  localparam int OSC_NOMINAL_HZ = 10000;
  // Byte lane positions inside the 24-bit reload value.
  localparam int UPPER_LSB = 16;
  localparam int MIDDLE_LSB = 8;
  localparam int LOWER_LSB = 0;
  localparam logic TIMEOUT_RESPONSE_RESET = 1'b1;
endpackage

// ### core/watchdog_reload_unlock.sv
// Reloadable 24-bit watchdog with unlock-guarded reload registers.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

// What this block does
// (R01) 24-bit down counter advanced by its own RC oscillator, not the system clock.
// (R02) Only ON and OFF; turns on by refresh, always-on option or debug mode, then counts.
// (R03) Always-on option starts the counter right after reset without any refresh.
// (R04) On first turn-on the counter loads the current 24-bit reload value.
// (R05) Each refresh reloads the counter; counting continues from the new value.
// (R06) Refresh is ignored once the count has reached 000002H.
// (R07) Software never programs a reload value below 000004H.
// (R08) Reload value is upper byte 23:16, middle byte 15:8, lower byte 7:0.
// (R09) One decrement per oscillator tick, nominally 10 kHz.
// (R10) Time-out at count zero; response option picks interrupt or system reset.
// (R11) In debug mode the counter is refreshed continuously, so no time-out.
// (R12) Interrupt mode, normal run: time-out raises interrupt and sets time-out status.
// (R13) After interrupt time-out the counter wraps to maximum, no automatic reload.
// (R14) Reading the reset status clears the time-out flag, blocking a repeat interrupt; here the interrupt pulses on every time-out, whatever the flag.
// (R15) Interrupt mode in STOP: start recovery, raise interrupt, set time-out and stop bits.
// (R16) Reset mode, normal run: time-out forces system reset and sets time-out status.
// (R17) Reset mode in STOP: start STOP recovery, set time-out and stop bits.
// (R18) Writing 55H then AAH to the unlock port unlocks; no control bits change.
// (R19) Reload bytes written upper, middle, lower; any other write relocks.
// (R20) Reload writes without a complete unlock sequence are ignored.
// (R21) Unlock port is write-only; reading its address returns reset status.
// (R22) Reading a reload byte returns that byte of the live counter.
// (R23) A write after 55H that is not AAH returns the unlock machine to idle.
module watchdog_reload_unlock #(
  parameter int ADDR_W = watchdog_reload_unlock_pkg::ADDR_W,
  parameter int DATA_W = watchdog_reload_unlock_pkg::DATA_W
) (
  // System clock and synchronous reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regReadData,
  // Core and option inputs, all on clk.
  input wire logic refreshInstruction,
  input wire logic alwaysOnOption,
  input wire logic timeoutResponseOption,
  input wire logic debugMode,
  input wire logic stopMode,
  // Dedicated RC oscillator, asynchronous to clk.
  input wire logic wdOscIn,
  // Time-out responses.
  output logic timeoutIrq,
  output logic systemResetReq,
  output logic stopRecoveryReq
);

  typedef enum logic [2:0] {
    LOCKED,
    GOT_FIRST,
    OPEN_UPPER,
    OPEN_MIDDLE,
    OPEN_LOWER
  } unlock_state_t;

  // Oscillator synchroniser and edge detector.
  logic oscMeta_q;
  logic oscSync_q;
  logic oscLast_q;
  logic oscTick;

  // Watchdog state.
  logic running_q, running_d;
  logic [23:0] count_q, count_d;
  logic [23:0] reload_q, reload_d;
  logic timeoutFlag_q, timeoutFlag_d;
  logic stopFlag_q, stopFlag_d;
  logic irq_q, irq_d;
  logic resetReq_q, resetReq_d;
  logic recovery_q, recovery_d;
  unlock_state_t unlock_q, unlock_d;
  logic [DATA_W-1:0] readData_q, readData_d;

  logic timeoutEvent;
  logic refreshTaken;
  logic statusRead;

  // Oscillator ticks cross by two flip-flops; the edge is taken between the second and a third flip-flop.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oscMeta_q <= 1'b0;
      oscSync_q <= 1'b0;
      oscLast_q <= 1'b0;
    end else begin
      oscMeta_q <= wdOscIn;
      oscSync_q <= oscMeta_q;
      oscLast_q <= oscSync_q;
    end
  end

  // (R09) one tick per edge
  assign oscTick = oscSync_q & ~oscLast_q;

  // (R06) refresh refused near zero
  assign refreshTaken = refreshInstruction && (count_q > watchdog_reload_unlock_pkg::REFRESH_FLOOR);

  // (R10) time-out at zero
  assign timeoutEvent = running_q && oscTick && !debugMode && (count_q == watchdog_reload_unlock_pkg::COUNT_ONE);

  assign statusRead = regRead && (regAddr == watchdog_reload_unlock_pkg::ADDR_UNLOCK_PORT);

  // Counter, on/off and time-out responses.
  always_comb begin
    running_d = running_q;
    count_d = count_q;
    irq_d = 1'b0;
    resetReq_d = 1'b0;
    recovery_d = 1'b0;
    timeoutFlag_d = timeoutFlag_q;
    stopFlag_d = stopFlag_q;
    if (!running_q) begin
      // (R02) turn on
      // (R03) always-on start
      if (refreshInstruction || alwaysOnOption || debugMode) begin
        running_d = 1'b1;
        // (R04) first load
        count_d = reload_q;
      end
    end else if (debugMode) begin
      // (R11) debug refresh
      count_d = reload_q;
    end else if (refreshTaken) begin
      // (R05) refresh reload
      count_d = reload_q;
    end else if (oscTick) begin
      // (R01) down count
      if (count_q == watchdog_reload_unlock_pkg::COUNT_ZERO) begin
        // (R13) wrap to max
        count_d = watchdog_reload_unlock_pkg::COUNT_MAX;
      end else begin
        count_d = count_q - watchdog_reload_unlock_pkg::COUNT_ONE;
      end
    end
    // (R14) read clears flags
    if (statusRead) begin
      timeoutFlag_d = 1'b0;
      stopFlag_d = 1'b0;
    end
    // A time-out in the same cycle as the status read still sets its flags.
    if (timeoutEvent) begin
      timeoutFlag_d = 1'b1;
      if (stopMode) begin
        // (R15) stop recovery, interrupt
        // (R17) stop recovery, reset mode
        stopFlag_d = 1'b1;
        recovery_d = 1'b1;
        irq_d = (timeoutResponseOption != watchdog_reload_unlock_pkg::TIMEOUT_RESPONSE_RESET);
      end else if (timeoutResponseOption == watchdog_reload_unlock_pkg::TIMEOUT_RESPONSE_RESET) begin
        // (R16) system reset
        resetReq_d = 1'b1;
      end else begin
        // (R12) interrupt request
        irq_d = 1'b1;
      end
    end
  end

  // Unlock machine and reload byte writes.
  always_comb begin
    unlock_d = unlock_q;
    reload_d = reload_q;
    if (regWrite) begin
      // (R19) any stray write relocks
      unlock_d = LOCKED;
      case (unlock_q)
        LOCKED: begin
          // (R20) locked writes ignored
          // (R18) first code
          if (regAddr == watchdog_reload_unlock_pkg::ADDR_UNLOCK_PORT &&
              regWriteData == watchdog_reload_unlock_pkg::UNLOCK_FIRST) begin
            unlock_d = GOT_FIRST;
          end
        end
        GOT_FIRST: begin
          // (R23) wrong second code
          if (regAddr == watchdog_reload_unlock_pkg::ADDR_UNLOCK_PORT &&
              regWriteData == watchdog_reload_unlock_pkg::UNLOCK_SECOND) begin
            unlock_d = OPEN_UPPER;
          end
        end
        OPEN_UPPER: begin
          // (R08) upper byte lane
          if (regAddr == watchdog_reload_unlock_pkg::ADDR_RELOAD_UPPER) begin
            reload_d[watchdog_reload_unlock_pkg::UPPER_LSB +: 8] = regWriteData;
            unlock_d = OPEN_MIDDLE;
          end
        end
        OPEN_MIDDLE: begin
          if (regAddr == watchdog_reload_unlock_pkg::ADDR_RELOAD_MIDDLE) begin
            reload_d[watchdog_reload_unlock_pkg::MIDDLE_LSB +: 8] = regWriteData;
            unlock_d = OPEN_LOWER;
          end
        end
        OPEN_LOWER: begin
          if (regAddr == watchdog_reload_unlock_pkg::ADDR_RELOAD_LOWER) begin
            reload_d[watchdog_reload_unlock_pkg::LOWER_LSB +: 8] = regWriteData;
          end
        end
        default: begin
          unlock_d = LOCKED;
        end
      endcase
    end
  end

  // Read data, answered in the cycle after the strobe.
  always_comb begin
    readData_d = '0;
    if (regRead) begin
      if (regAddr == watchdog_reload_unlock_pkg::ADDR_UNLOCK_PORT) begin
        // (R21) status at unlock address
        readData_d[watchdog_reload_unlock_pkg::STATUS_TIMEOUT_BIT] = timeoutFlag_q;
        readData_d[watchdog_reload_unlock_pkg::STATUS_STOP_BIT] = stopFlag_q;
      end else if (regAddr == watchdog_reload_unlock_pkg::ADDR_RELOAD_UPPER) begin
        // (R22) live count bytes
        readData_d = count_q[watchdog_reload_unlock_pkg::UPPER_LSB +: 8];
      end else if (regAddr == watchdog_reload_unlock_pkg::ADDR_RELOAD_MIDDLE) begin
        readData_d = count_q[watchdog_reload_unlock_pkg::MIDDLE_LSB +: 8];
      end else if (regAddr == watchdog_reload_unlock_pkg::ADDR_RELOAD_LOWER) begin
        readData_d = count_q[watchdog_reload_unlock_pkg::LOWER_LSB +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      running_q <= 1'b0;
      count_q <= watchdog_reload_unlock_pkg::RELOAD_RESET;
      reload_q <= watchdog_reload_unlock_pkg::RELOAD_RESET;
      timeoutFlag_q <= 1'b0;
      stopFlag_q <= 1'b0;
      irq_q <= 1'b0;
      resetReq_q <= 1'b0;
      recovery_q <= 1'b0;
      unlock_q <= LOCKED;
      readData_q <= '0;
    end else begin
      running_q <= running_d;
      count_q <= count_d;
      reload_q <= reload_d;
      timeoutFlag_q <= timeoutFlag_d;
      stopFlag_q <= stopFlag_d;
      irq_q <= irq_d;
      resetReq_q <= resetReq_d;
      recovery_q <= recovery_d;
      unlock_q <= unlock_d;
      readData_q <= readData_d;
    end
  end

  assign regReadData = readData_q;
  assign timeoutIrq = irq_q;
  assign systemResetReq = resetReq_q;
  assign stopRecoveryReq = recovery_q;

endmodule

// ### testbench/watchdog_reload_unlock_props.sv
// Port-level checks on the reloadable watchdog.
`timescale 1ns/1ps
module watchdog_reload_unlock_props #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regRead,
  input wire logic [DATA_W-1:0] regReadData,
  // Options and modes.
  input wire logic timeoutResponseOption,
  input wire logic debugMode,
  input wire logic stopMode,
  // Responses.
  input wire logic timeoutIrq,
  input wire logic systemResetReq,
  input wire logic stopRecoveryReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  read_idle_zero_a: assert property (!$past(regRead) |-> regReadData == '0)
    else $error("read data not zero outside an answer");
  unmapped_zero_a: assert property ($past(regRead) && $past(regAddr) < 12'hff0 |-> regReadData == '0)
    else $error("unmapped read not zero");
  status_layout_a: assert property ($past(regRead) && $past(regAddr) == 12'hff0 |-> regReadData[7:6] == 2'h0
    && regReadData[3:0] == 4'h0)
    else $error("status byte has stray bits");
  debug_quiet_a: assert property (debugMode [*3] |=> !timeoutIrq && !systemResetReq && !stopRecoveryReq)
    else $error("time-out while in debug");
  irq_mode_a: assert property (timeoutIrq |-> !$past(timeoutResponseOption))
    else $error("interrupt in reset response mode");
  reset_normal_a: assert property (systemResetReq |-> $past(timeoutResponseOption) && !$past(stopMode))
    else $error("system reset outside normal reset mode");
  recovery_stop_a: assert property (stopRecoveryReq |-> $past(stopMode) && !systemResetReq)
    else $error("recovery outside stop or with reset");
  stop_irq_pair_a: assert property (stopRecoveryReq && !$past(timeoutResponseOption) |-> timeoutIrq)
    else $error("stop time-out without interrupt");
  irq_pulse_a: assert property (timeoutIrq |=> !timeoutIrq [*2])
    else $error("interrupt repeated");
endmodule
bind watchdog_reload_unlock watchdog_reload_unlock_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) props_u (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regRead(regRead), .regReadData(regReadData),
  .timeoutResponseOption(timeoutResponseOption), .debugMode(debugMode), .stopMode(stopMode),
  .timeoutIrq(timeoutIrq), .systemResetReq(systemResetReq), .stopRecoveryReq(stopRecoveryReq));

// ### testbench/watchdog_far_side.sv
// Interrupt controller and reset unit that tally the watchdog's requests.
`timescale 1ns/1ps
module watchdog_far_side (
  // Clock.
  input wire logic clk,
  // Requests.
  input wire logic timeoutIrq,
  input wire logic systemResetReq,
  input wire logic stopRecoveryReq,
  // Tallies.
  output int irqSeen,
  output int resetSeen,
  output int recoverySeen
);
  initial irqSeen = 0;
  initial resetSeen = 0;
  initial recoverySeen = 0;
  always @(posedge clk) begin
    irqSeen <= irqSeen + int'(timeoutIrq);
    resetSeen <= resetSeen + int'(systemResetReq);
    recoverySeen <= recoverySeen + int'(stopRecoveryReq);
  end
endmodule

// ### testbench/watchdog_reload_unlock_tb_top.sv
// Self-checking bench for the reloadable watchdog.
`timescale 1ns/1ps
module watchdog_reload_unlock_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, refreshInstruction = 1'b0;
  logic alwaysOnOption = 1'b0, timeoutResponseOption = 1'b0, debugMode = 1'b0, stopMode = 1'b0, wdOscIn = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWriteData = 8'h00;
  logic [7:0] regReadData;
  logic timeoutIrq, systemResetReq, stopRecoveryReq;
  logic [31:0] seed = 32'h310f;
  int irqSeen, resetSeen, recoverySeen, cnt, rel, st, on, toFlag, stopFlag;
  int irqExp = 0, rstExp = 0, recExp = 0, fails = 0, checked = 0;
  watchdog_reload_unlock dut_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .refreshInstruction(refreshInstruction),
    .alwaysOnOption(alwaysOnOption), .timeoutResponseOption(timeoutResponseOption), .debugMode(debugMode),
    .stopMode(stopMode), .wdOscIn(wdOscIn), .timeoutIrq(timeoutIrq), .systemResetReq(systemResetReq),
    .stopRecoveryReq(stopRecoveryReq));
  watchdog_far_side far_u (.clk(clk), .timeoutIrq(timeoutIrq), .systemResetReq(systemResetReq),
    .stopRecoveryReq(stopRecoveryReq), .irqSeen(irqSeen), .resetSeen(resetSeen), .recoverySeen(recoverySeen));
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic model_reset();
    cnt = 24'hffffff;
    rel = 24'hffffff;
    st = 0;
    on = alwaysOnOption;
    toFlag = 0;
    stopFlag = 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    // The unlock machine only advances on the exact next write; anything else relocks it.
    if (st >= 2 && a == 12'hfef + st) begin
      rel[(4 - st) * 8 +: 8] = d;
      st = (st + 1) % 5;
    end else begin
      st = (a == 12'hff0 && ((st == 0 && d == 8'h55) || (st == 1 && d == 8'haa))) ? st + 1 : 0;
    end
  endtask
  task automatic rd(input logic [11:0] a);
    logic [7:0] e;
    if (a >= 12'hff1 && a <= 12'hff3) e = 8'(cnt >> (8 * (12'hff3 - a)));
    else if (a == 12'hff0) e = {2'b00, toFlag[0], stopFlag[0], 4'h0};
    else e = 8'h00;
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    if (a == 12'hff0) begin
      toFlag = 0;
      stopFlag = 0;
    end
    #1;
    cmp(regReadData, e);
  endtask
  task automatic program_reload(input logic [7:0] lo);
    wr(12'hff0, 8'h55);
    wr(12'hff0, 8'haa);
    wr(12'hff1, 8'h00);
    wr(12'hff2, 8'h00);
    wr(12'hff3, lo);
  endtask
  task automatic refresh();
    @(posedge clk);
    refreshInstruction <= 1'b1;
    @(posedge clk);
    refreshInstruction <= 1'b0;
    if (!on || cnt > 2) cnt = rel;
    on = 1;
  endtask
  // The oscillator pulse is held long enough to pass the two-stage synchroniser.
  task automatic tick();
    @(posedge clk);
    wdOscIn <= 1'b1;
    repeat (4) @(posedge clk);
    wdOscIn <= 1'b0;
    repeat (4) @(posedge clk);
    if (debugMode) cnt = rel;
    else if (on && cnt == 0) cnt = 24'hffffff;
    else if (on) begin
      cnt--;
      if (cnt == 0) begin
        toFlag = 1;
        stopFlag = stopFlag | stopMode;
        irqExp += !timeoutResponseOption;
        rstExp += timeoutResponseOption & !stopMode;
        recExp += stopMode;
      end
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end
  initial begin
    model_reset();
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'hff1);
    rd(12'hff0);
    rd(12'h100);
    tick();
    rd(12'hff3);
    wr(12'hff1, 8'h00);
    wr(12'hff0, 8'h55);
    wr(12'hff0, seed[7:0] & 8'h0f);
    wr(12'hff0, 8'haa);
    wr(12'hff1, 8'h00);
    wr(12'hff0, 8'h55);
    wr(12'hff0, 8'haa);
    wr(12'hff1, 8'h00);
    wr(12'h100, 8'h00);
    wr(12'hff2, 8'h00);
    refresh();
    rd(12'hff1);
    rd(12'hff2);
    for (int m = 0; m < 4; m++) begin
      timeoutResponseOption <= m[0];
      stopMode <= m[1];
      seed = xorshift(seed);
      // Reload values stay at 000004H or above, as software must keep them.
      program_reload(8'h04 + (seed[7:0] & 8'h07));
      refresh();
      rd(12'hff3);
      while (cnt > 2) tick();
      refresh();
      rd(12'hff3);
      tick();
      tick();
      rd(12'hff0);
      rd(12'hff0);
      tick();
      rd(12'hff1);
    end
    debugMode <= 1'b1;
    tick();
    rd(12'hff3);
    debugMode <= 1'b0;
    cmp(8'(irqSeen), 8'(irqExp));
    cmp(8'(resetSeen), 8'(rstExp));
    cmp(8'(recoverySeen), 8'(recExp));
    rst_n <= 1'b0;
    alwaysOnOption <= 1'b1;
    repeat (10) @(posedge clk);
    model_reset();
    rst_n <= 1'b1;
    tick();
    rd(12'hff3);
    wrap_up();
  end
endmodule
